// ==== hw/vps_pkg.sv ====
/*
 Constants and types for the emulated PHY status and identifier registers.
 Assumes a single 125 MHz core clock with synchronous active-high reset.
*/
//==============================================================
// Summary of operation
// - Status bits 15, 10 and 9 always read zero, so T4 and T2 modes are not offered.
// - Status bits 14 to 11 read one for 100 full, 100 half, 10 full and 10 half duplex.
// - Status bit 8 reads zero, as there is no extended status register and no gigabit.
// - Status bit 6 reads zero, so the master must send a full preamble on every frame.
// - The negotiation-complete bit 5 clears on reset and sets a short time later.
// - Remote fault bit 4 and jabber bit 1 read zero, and link bit 2 reads one, always.
// - Status bit 3 reads one to report that auto-negotiation is possible.
// - Status bit 0 reads one for extended capability, with only indices 1 to 3 present.
// - Bits 31 to 16 read zero in the word map, serial access sees 16 bits, bit 7 reads zero.
// - The identifier high register at index 2 holds a 16-bit read/write OUI field.
// - The identifier low register holds six read/write OUI bits in 15 to 10, reset zero.
// - Bits 9 to 4 of identifier low are a read/write model number, reset zero.
// - Bits 3 to 0 of identifier low are a read/write revision number, reset zero.
// - An all-zero identifier is stored and returned as written.
// - The status register sits at serial index 1 and at byte offset 1C4h.
package vps_pkg;
   //==============================================================
   // Timing
   localparam int CLK_PERIOD_NS = 8;
   localparam int AN_TIME_NS = 1000;
   localparam int AN_CYCLES = (AN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] AN_LAST = 8'(AN_CYCLES - 1);

   //==============================================================
   // Address map
   localparam logic [8:0] OFS_STATUS = 9'h1C4;
   localparam logic [8:0] OFS_IDH = 9'h1C8;
   localparam logic [8:0] OFS_IDL = 9'h1CC;
   localparam logic [4:0] IDX_STATUS = 5'h01;
   localparam logic [4:0] IDX_IDH = 5'h02;
   localparam logic [4:0] IDX_IDL = 5'h03;

   //==============================================================
   // Status bit positions
   localparam int B_T4 = 15;
   localparam int B_100FD = 14;
   localparam int B_100HD = 13;
   localparam int B_10FD = 12;
   localparam int B_10HD = 11;
   localparam int B_T2FD = 10;
   localparam int B_T2HD = 9;
   localparam int B_EXTST = 8;
   localparam int B_RSVD = 7;
   localparam int B_PRESUP = 6;
   localparam int B_ANDONE = 5;
   localparam int B_RFAULT = 4;
   localparam int B_ANABLE = 3;
   localparam int B_LINK = 2;
   localparam int B_JABBER = 1;
   localparam int B_EXTCAP = 0;
   localparam logic [15:0] ONE16 = 16'h0001;
   localparam logic [15:0] STATUS_FIXED = (ONE16 << B_100FD) | (ONE16 << B_100HD) |
      (ONE16 << B_10FD) | (ONE16 << B_10HD) | (ONE16 << B_ANABLE) |
      (ONE16 << B_LINK) | (ONE16 << B_EXTCAP);

   //==============================================================
   // Serial management frame
   localparam logic [5:0] PRE_LEN = 6'h20;
   localparam logic [5:0] HDR_LAST = 6'h0C;
   localparam logic [5:0] TA_LAST = 6'h01;
   localparam logic [5:0] DATA_LAST = 6'h0F;
   localparam logic [5:0] DATA_END = 6'h10;
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] OP_WRITE = 2'h1;

   typedef struct packed {
      logic st;
      logic [1:0] op;
      logic [4:0] phy;
      logic [4:0] idx;
   } vps_hdr_t;

   typedef struct packed {
      logic [5:0] oui_lo;
      logic [5:0] model;
      logic [3:0] rev;
   } vps_ident_low_t;

   localparam logic [15:0] IDH_RESET = 16'h0000;
   localparam vps_ident_low_t IDL_RESET = '{oui_lo: 6'h00, model: 6'h00, rev: 4'h0};

   typedef enum {S_PRE, S_HDR, S_RTA, S_RD, S_WTA, S_WR} vps_state_t;
endpackage

// ==== hw/vps_regs.sv ====
/*
 Emulated PHY status and identifier registers, reachable over the serial
 management pins and over a simple 32-bit word register port.
 Assumes MDC is far slower than the core clock and that the master
 changes MDIO away from the rising MDC edge.
*/
`timescale 1ns/1ns
module vps_regs (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [4:0] i_phy_addr,
   input wire logic i_mdc,
   input wire logic i_mdio,
   output logic o_mdio,
   output logic o_mdio_oe,
   input wire logic [8:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [31:0] i_reg_wdata,
   output logic [31:0] o_reg_rdata
);
   localparam int ANB = vps_pkg::AN_CYCLES;

   logic [2:0] mdc_sync_r;
   logic [1:0] mdio_sync_r;
   logic mdc_rise;
   logic mdio_bit;
   logic [7:0] an_cnt_r;
   logic an_done_r;
   logic [15:0] status_w;
   logic [15:0] id_hi_r;
   vps_pkg::vps_ident_low_t id_lo_r;
   vps_pkg::vps_state_t state_r;
   logic [5:0] pre_cnt_r;
   logic [5:0] bit_cnt_r;
   vps_pkg::vps_hdr_t hdr_r;
   vps_pkg::vps_hdr_t hdr_nxt;
   logic [15:0] shift_r;
   logic mdio_r;
   logic mdio_oe_r;
   logic mw_go;
   logic [15:0] mw_data;
   logic bus_wr_idh;
   logic bus_wr_idl;
   logic [15:0] bus_rd16;
   logic [31:0] rdata_r;

   //==============================================================
   // Pin synchronisers
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         mdc_sync_r <= 3'h0;
         mdio_sync_r <= 2'h0;
      end else begin
         mdc_sync_r <= {mdc_sync_r[1:0], i_mdc};
         mdio_sync_r <= {mdio_sync_r[0], i_mdio};
      end
   end

   // Third stage only remembers the last level for edge detection
   assign mdc_rise = mdc_sync_r[1] & ~mdc_sync_r[2];
   assign mdio_bit = mdio_sync_r[1];

   //==============================================================
   // Emulated negotiation
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         an_cnt_r <= 8'h00;
         an_done_r <= 1'b0;
      end else if (!an_done_r) begin
         if (an_cnt_r == vps_pkg::AN_LAST) begin
            an_done_r <= 1'b1;
         end else begin
            an_cnt_r <= an_cnt_r + 8'h01;
         end
      end
   end

   // Sets once and stays; this block has no restart path
   // Only the negotiation bit varies; the rest is wired
   assign status_w = vps_pkg::STATUS_FIXED | ({15'h0000, an_done_r} << vps_pkg::B_ANDONE);
   // come from the fixed pattern above

   function automatic logic [15:0] rd16(input logic [4:0] idx, input logic [15:0] st,
                                        input logic [15:0] idh, input logic [15:0] idl);
      case (idx)
         vps_pkg::IDX_STATUS: rd16 = st;
         vps_pkg::IDX_IDH: rd16 = idh;
         vps_pkg::IDX_IDL: rd16 = idl;
         default: rd16 = 16'h0000;
      endcase
   endfunction

   //==============================================================
   // Serial management frame engine
   // Ones saturate at 32, so idle ones between frames count as preamble
   assign hdr_nxt = vps_pkg::vps_hdr_t'({hdr_r[11:0], mdio_bit});

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state_r <= vps_pkg::S_PRE;
         pre_cnt_r <= 6'h00;
         bit_cnt_r <= 6'h00;
         hdr_r <= '0;
         shift_r <= 16'h0000;
         mdio_r <= 1'b0;
         mdio_oe_r <= 1'b0;
      end else if (mdc_rise) begin
         case (state_r)
            vps_pkg::S_PRE: begin
               if (mdio_bit) begin
                  if (pre_cnt_r != vps_pkg::PRE_LEN) begin
                     pre_cnt_r <= pre_cnt_r + 6'h01;
                  end
               end else if (pre_cnt_r == vps_pkg::PRE_LEN) begin
                  state_r <= vps_pkg::S_HDR;
                  bit_cnt_r <= 6'h00;
               end else begin
                  pre_cnt_r <= 6'h00;
               end
            end
            vps_pkg::S_HDR: begin
               hdr_r <= hdr_nxt;
               if (bit_cnt_r == vps_pkg::HDR_LAST) begin
                  bit_cnt_r <= 6'h00;
                  pre_cnt_r <= 6'h00;
                  state_r <= vps_pkg::S_PRE;
                  if (hdr_nxt.st && hdr_nxt.phy == i_phy_addr) begin
                     if (hdr_nxt.op == vps_pkg::OP_READ) begin
                        state_r <= vps_pkg::S_RTA;
                        shift_r <= rd16(hdr_nxt.idx, status_w, id_hi_r, id_lo_r);
                     end else if (hdr_nxt.op == vps_pkg::OP_WRITE) begin
                        state_r <= vps_pkg::S_WTA;
                     end
                  end
               end else begin
                  bit_cnt_r <= bit_cnt_r + 6'h01;
               end
            end
            vps_pkg::S_RTA: begin
               mdio_oe_r <= 1'b1;
               mdio_r <= 1'b0;
               state_r <= vps_pkg::S_RD;
            end
            vps_pkg::S_RD: begin
               if (bit_cnt_r == vps_pkg::DATA_END) begin
                  mdio_oe_r <= 1'b0;
                  mdio_r <= 1'b0;
                  bit_cnt_r <= 6'h00;
                  state_r <= vps_pkg::S_PRE;
               end else begin
                  mdio_r <= shift_r[15];
                  shift_r <= {shift_r[14:0], 1'b0};
                  bit_cnt_r <= bit_cnt_r + 6'h01;
               end
            end
            vps_pkg::S_WTA: begin
               if (bit_cnt_r == vps_pkg::TA_LAST) begin
                  bit_cnt_r <= 6'h00;
                  state_r <= vps_pkg::S_WR;
               end else begin
                  bit_cnt_r <= bit_cnt_r + 6'h01;
               end
            end
            vps_pkg::S_WR: begin
               shift_r <= {shift_r[14:0], mdio_bit};
               if (bit_cnt_r == vps_pkg::DATA_LAST) begin
                  bit_cnt_r <= 6'h00;
                  state_r <= vps_pkg::S_PRE;
               end else begin
                  bit_cnt_r <= bit_cnt_r + 6'h01;
               end
            end
            default: begin
               state_r <= vps_pkg::S_PRE;
               mdio_oe_r <= 1'b0;
            end
         endcase
      end
   end

   assign o_mdio = mdio_r;
   assign o_mdio_oe = mdio_oe_r;
   assign mw_go = mdc_rise && state_r == vps_pkg::S_WR && bit_cnt_r == vps_pkg::DATA_LAST;
   assign mw_data = {shift_r[14:0], mdio_bit};

   //==============================================================
   // Identifier storage; word port wins a same-cycle clash
   assign bus_wr_idh = i_reg_wr && i_reg_addr == vps_pkg::OFS_IDH;
   assign bus_wr_idl = i_reg_wr && i_reg_addr == vps_pkg::OFS_IDL;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         id_hi_r <= vps_pkg::IDH_RESET;
         id_lo_r <= vps_pkg::IDL_RESET;
      end else begin
         if (bus_wr_idh) begin
            id_hi_r <= i_reg_wdata[15:0];
         end else if (mw_go && hdr_r.idx == vps_pkg::IDX_IDH) begin
            id_hi_r <= mw_data;
         end
         if (bus_wr_idl) begin
            id_lo_r <= vps_pkg::vps_ident_low_t'(i_reg_wdata[15:0]);
         end else if (mw_go && hdr_r.idx == vps_pkg::IDX_IDL) begin
            id_lo_r <= vps_pkg::vps_ident_low_t'(mw_data);
         end
      end
   end
   // Status has no write path at all, so writes there fall away

   //==============================================================
   // Word port read
   // A read on the edge of a write returns the old value
   always_comb begin
      case (i_reg_addr)
         vps_pkg::OFS_STATUS: bus_rd16 = status_w;
         vps_pkg::OFS_IDH: bus_rd16 = id_hi_r;
         vps_pkg::OFS_IDL: bus_rd16 = id_lo_r;
         default: bus_rd16 = 16'h0000;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         rdata_r <= 32'h0000_0000;
      end else if (i_reg_rd) begin
         rdata_r <= {16'h0000, bus_rd16};
      end
   end

   assign o_reg_rdata = rdata_r;

   //==============================================================
   // Checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   sequence st_rd;
      i_reg_rd && i_reg_addr == vps_pkg::OFS_STATUS;
   endsequence

   a_no_t4_t2: assert property (st_rd |=> o_reg_rdata[15] == 1'b0 && o_reg_rdata[10:9] == 2'h0)
      else $error("T4 or T2 ability bit set");
   a_abilities_set: assert property (st_rd |=> o_reg_rdata[14:11] == 4'hF)
      else $error("10/100 ability bits not all set");
   a_no_ext_status: assert property (st_rd |=> o_reg_rdata[8] == 1'b0)
      else $error("extended status bit set");
   a_no_pre_supp: assert property (st_rd |=> o_reg_rdata[6] == 1'b0)
      else $error("preamble suppression bit set");
   a_fault_link: assert property (st_rd |=> o_reg_rdata[4:1] == 4'h6)
      else $error("fault, ability, link or jabber bits wrong");
   a_ext_cap: assert property (st_rd |=> o_reg_rdata[0] == 1'b1)
      else $error("extended capability bit clear");
   a_pad_zero: assert property (i_reg_rd |=> o_reg_rdata[31:16] == 16'h0000 &&
      ($past(i_reg_addr) != vps_pkg::OFS_STATUS || o_reg_rdata[7] == 1'b0))
      else $error("padding or reserved bit nonzero");
   a_an_clear: assert property (disable iff (1'b0) i_rst |=> !an_done_r)
      else $error("negotiation done not cleared by reset");
   a_an_sets: assert property (!an_done_r |-> ##[1:ANB] an_done_r)
      else $error("negotiation done late");
   a_an_reads: assert property (st_rd |=> o_reg_rdata[5] == $past(an_done_r))
      else $error("negotiation done bit not reported");
   a_idh_write: assert property (bus_wr_idh |=> id_hi_r == $past(i_reg_wdata[15:0]))
      else $error("ident high write lost");
   a_idl_write: assert property (bus_wr_idl |=> id_lo_r == $past(i_reg_wdata[15:0]))
      else $error("ident low write lost");
   a_id_reset: assert property (disable iff (1'b0) i_rst |=> id_lo_r == 16'h0000)
      else $error("ident low not reset to zero");
   a_status_ro: assert property (i_reg_wr && i_reg_addr == vps_pkg::OFS_STATUS ##1 st_rd
      |=> o_reg_rdata[15:6] == 10'h1E0)
      else $error("status changed by write");
   a_mdio_turn: assert property (mdc_rise && state_r == vps_pkg::S_RTA
      |=> o_mdio_oe && !o_mdio)
      else $error("turnaround zero not driven");
   a_oe_only_read: assert property (o_mdio_oe |-> state_r == vps_pkg::S_RD)
      else $error("pin driven outside read data");

   a_an_holds: assert property (an_done_r |=> an_done_r)
      else $error("negotiation done dropped without reset");

   // A word-port write on the same edge takes precedence
   a_ser_idh_write: assert property (mw_go && hdr_r.idx == vps_pkg::IDX_IDH && !bus_wr_idh
      |=> id_hi_r == $past(mw_data))
      else $error("serial ident high write lost");
   a_ser_idl_write: assert property (mw_go && hdr_r.idx == vps_pkg::IDX_IDL && !bus_wr_idl
      |=> id_lo_r == $past(mw_data))
      else $error("serial ident low write lost");

   a_rd_release: assert property (mdc_rise && state_r == vps_pkg::S_RD &&
      bit_cnt_r == vps_pkg::DATA_END |=> !o_mdio_oe)
      else $error("pin still driven after last data bit");

   a_ser_status: assert property (mdc_rise && state_r == vps_pkg::S_HDR &&
      bit_cnt_r == vps_pkg::HDR_LAST && hdr_nxt.st && hdr_nxt.phy == i_phy_addr &&
      hdr_nxt.op == vps_pkg::OP_READ && hdr_nxt.idx == vps_pkg::IDX_STATUS
      |=> shift_r == $past(status_w))
      else $error("serial status read not loaded");

   //==============================================================
   // Coverage
   c_status_read: cover property (st_rd ##1 o_reg_rdata[5]);
   c_mdio_read: cover property (mdc_rise && state_r == vps_pkg::S_RD && bit_cnt_r == 6'h10);
   c_mdio_write: cover property (mw_go && hdr_r.idx == vps_pkg::IDX_IDL);
   c_an_done: cover property ($rose(an_done_r));
   c_ser_idh_write: cover property (mw_go && hdr_r.idx == vps_pkg::IDX_IDH);
endmodule

// ==== verification/vps_mdio_master.sv ====
/*
 Behavioural management-bus master that drives frames into the emulated PHY registers.
 Assumes the bench resolves the shared data line, with a pull-up when nobody drives it.
*/
`timescale 1ns/1ns
module vps_mdio_master (
   input wire logic i_clk,
   input wire logic i_mdio,
   output logic o_mdc,
   output logic o_mdio,
   output logic o_mdio_oe
);
   //==============================================================
   // Bit timing
   // Management clock parks low between frames, five core clocks per half period
   initial begin
      o_mdc = 1'h0;
      o_mdio = 1'h1;
      o_mdio_oe = 1'h0;
   end

   task automatic half_period();
      repeat (5) @(negedge i_clk);
   endtask

   // Data changes only while the clock is low, well away from the rising edge
   task automatic send_bit(input logic b);
      o_mdio_oe = 1'h1;
      o_mdio = b;
      half_period();
      o_mdc = 1'h1;
      half_period();
      o_mdc = 1'h0;
   endtask

   task automatic take_bit(output logic b);
      o_mdio_oe = 1'h0;
      half_period();
      b = i_mdio;
      o_mdc = 1'h1;
      half_period();
      o_mdc = 1'h0;
   endtask

   //==============================================================
   // Whole frame
   // Bit 16 of rd is the second turnaround bit, bits 15:0 the data
   task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] idx,
      input logic [15:0] wd, input int pre_len, output logic [16:0] rd);
      logic [13:0] hdr;
      logic b;
      hdr = {2'h1, op, phy, idx};
      rd = '0;
      for (int i = 0; i < pre_len; i++) send_bit(1'h1);
      for (int i = 13; i >= 0; i--) send_bit(hdr[i]);
      if (op == 2'h2) begin
         take_bit(b);
         for (int i = 16; i >= 0; i--) begin
            take_bit(b);
            rd[i] = b;
         end
      end else begin
         send_bit(1'h1);
         send_bit(1'h0);
         for (int i = 15; i >= 0; i--) send_bit(wd[i]);
      end
      o_mdio_oe = 1'h0;
      half_period();
      half_period();
   endtask
endmodule

// ==== verification/tb_top.sv ====
/*
 Self-checking bench for the emulated PHY status and identifier registers.
 Assumes the design package and the management master model are compiled first.
*/
`timescale 1ns/1ns
module tb_top;
   typedef struct packed {
      logic wr;
      logic [8:0] addr;
      logic [31:0] wdata;
      logic [31:0] exp;
   } vps_row_t;

   localparam logic [4:0] PHY = 5'h0B;
   logic i_clk = 1'h0;
   logic i_rst = 1'h1;
   logic [8:0] reg_addr = 9'h000;
   logic reg_wr = 1'h0;
   logic reg_rd = 1'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic [31:0] reg_rdata;
   logic mdc, m_mdio, m_oe, d_mdio, d_oe, line;
   int fails = 0;
   int checks_done = 0;
   vps_row_t rows[13] = '{
      '{1'h0, 9'h1C4, 32'h0, 32'h0000782D},
      '{1'h1, 9'h1C4, 32'hFFFFFFFF, 32'h0},
      '{1'h0, 9'h1C4, 32'h0, 32'h0000782D},
      '{1'h1, 9'h1C8, 32'hFFFFA5C3, 32'h0},
      '{1'h0, 9'h1C8, 32'h0, 32'h0000A5C3},
      '{1'h1, 9'h1CC, 32'hFFFF1234, 32'h0},
      '{1'h0, 9'h1CC, 32'h0, 32'h00001234},
      '{1'h0, 9'h1C0, 32'h0, 32'h0},
      '{1'h1, 9'h1C8, 32'h0, 32'h0},
      '{1'h0, 9'h1C8, 32'h0, 32'h0},
      '{1'h1, 9'h1CC, 32'h0, 32'h0},
      '{1'h0, 9'h1CC, 32'h0, 32'h0},
      '{1'h0, 9'h1D0, 32'h0, 32'h0}
   };

   always #4 i_clk = ~i_clk;
   // Pull-up: a released line reads one
   assign line = d_oe ? d_mdio : (m_oe ? m_mdio : 1'h1);

   vps_regs u_dut (
      .i_clk(i_clk), .i_rst(i_rst), .i_phy_addr(PHY), .i_mdc(mdc), .i_mdio(line),
      .o_mdio(d_mdio), .o_mdio_oe(d_oe), .i_reg_addr(reg_addr), .i_reg_wr(reg_wr),
      .i_reg_rd(reg_rd), .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata)
   );
   vps_mdio_master u_mst (
      .i_clk(i_clk), .i_mdio(line), .o_mdc(mdc), .o_mdio(m_mdio), .o_mdio_oe(m_oe)
   );

   //==============================================================
   // Helpers
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic finish_test();
      $display("Counts: %0d checks, %0d failures", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic wr_word(input logic [8:0] a, input logic [31:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'h1;
      @(negedge i_clk);
      reg_wr = 1'h0;
   endtask

   task automatic rd_chk(input logic [8:0] a, input logic [31:0] exp);
      reg_addr = a;
      reg_rd = 1'h1;
      @(negedge i_clk);
      reg_rd = 1'h0;
      @(negedge i_clk);
      check(reg_rdata, exp);
   endtask

   // Expected value carries the turnaround bit in bit 16
   task automatic ser_rd(input logic [4:0] phy, input logic [4:0] idx, input int pre,
      input logic [31:0] exp);
      logic [16:0] rd;
      u_mst.frame(2'h2, phy, idx, 16'h0, pre, rd);
      check({15'h0, rd}, exp);
   endtask

   task automatic ser_wr(input logic [4:0] idx, input logic [15:0] wd);
      logic [16:0] rd;
      u_mst.frame(2'h1, PHY, idx, wd, 32, rd);
   endtask

   //==============================================================
   // Main sequence
   initial begin
      repeat (10) @(negedge i_clk);
      i_rst = 1'h0;
      rd_chk(9'h1C4, 32'h0000780D);
      rd_chk(9'h1C8, 32'h0);
      rd_chk(9'h1CC, 32'h0);
      repeat (100) @(negedge i_clk);
      rd_chk(9'h1C4, 32'h0000780D);
      repeat (30) @(negedge i_clk);
      foreach (rows[i]) begin
         if (rows[i].wr) begin
            wr_word(rows[i].addr, rows[i].wdata);
         end else begin
            rd_chk(rows[i].addr, rows[i].exp);
         end
      end
      ser_rd(PHY, 5'h01, 32, 32'h0000782D);
      ser_wr(5'h02, 16'hC3A5);
      repeat (4) @(negedge i_clk);
      rd_chk(9'h1C8, 32'h0000C3A5);
      wr_word(9'h1CC, 32'h0000ABCD);
      ser_rd(PHY, 5'h03, 32, 32'h0000ABCD);
      ser_wr(5'h03, 16'h5A96);
      repeat (4) @(negedge i_clk);
      rd_chk(9'h1CC, 32'h00005A96);
      ser_wr(5'h01, 16'h0000);
      ser_rd(PHY, 5'h01, 32, 32'h0000782D);
      ser_rd(PHY, 5'h05, 32, 32'h0);
      // Short preamble right after a read that ended on zeros, so no idle ones count
      ser_rd(PHY, 5'h01, 31, 32'h0001FFFF);
      ser_rd(5'h0C, 5'h01, 32, 32'h0001FFFF);
      // Second reset in mid-run must clear the identifier and negotiation state
      i_rst = 1'h1;
      repeat (2) @(negedge i_clk);
      i_rst = 1'h0;
      rd_chk(9'h1C8, 32'h0);
      rd_chk(9'h1CC, 32'h0);
      rd_chk(9'h1C4, 32'h0000780D);
      finish_test();
   end

   // Whole run needs about 6000 cycles; five times that is a hang
   initial begin
      #(30000 * 8);
      fails++;
      finish_test();
   end
endmodule
